//--- hdl/vrf_consts.vh
// Constants for the compact voice payload framer
`ifndef VRF_CONSTS_VH
`define VRF_CONSTS_VH
// Payload sizes in bits
`define VRF_SZ_SID      12'h030
`define VRF_SZ_SHARED   12'h038
`define VRF_SZ_IO_0660  12'h088
`define VRF_SZ_P_0720   12'h090
`define VRF_SZ_P_0800   12'h0A0
`define VRF_SZ_IO_0885  12'h0B8
`define VRF_SZ_P_0960   12'h0C0
`define VRF_SZ_IO_1265  12'h100
`define VRF_SZ_P_1320   12'h108
`define VRF_SZ_IO_1425  12'h120
`define VRF_SZ_IO_1585  12'h140
`define VRF_SZ_P_1640   12'h148
`define VRF_SZ_IO_1825  12'h170
`define VRF_SZ_IO_1985  12'h190
`define VRF_SZ_IO_2305  12'h1D0
`define VRF_SZ_IO_2385  12'h1E0
`define VRF_SZ_P_2440   12'h1E8
`define VRF_SZ_P_3200   12'h280
`define VRF_SZ_P_4800   12'h3C0
`define VRF_SZ_P_6400   12'h500
`define VRF_SZ_P_9600   12'h780
`define VRF_SZ_P_12800  12'hA00
// Rate codes reported on o_rate_code
`define VRF_RATE_INVALID 5'h1F
`define VRF_RATE_P_SID   5'h00
`define VRF_RATE_P_2800  5'h01
`define VRF_RATE_IO_SID  5'h02
`define VRF_RATE_P_0720  5'h03
`define VRF_RATE_P_0800  5'h04
`define VRF_RATE_P_0960  5'h05
`define VRF_RATE_P_1320  5'h06
`define VRF_RATE_P_1640  5'h07
`define VRF_RATE_P_2440  5'h08
`define VRF_RATE_P_3200  5'h09
`define VRF_RATE_P_4800  5'h0A
`define VRF_RATE_P_6400  5'h0B
`define VRF_RATE_P_9600  5'h0C
`define VRF_RATE_P_12800 5'h0D
`define VRF_RATE_IO_0660 5'h10
`define VRF_RATE_IO_0885 5'h11
`define VRF_RATE_IO_1265 5'h12
`define VRF_RATE_IO_1425 5'h13
`define VRF_RATE_IO_1585 5'h14
`define VRF_RATE_IO_1825 5'h15
`define VRF_RATE_IO_1985 5'h16
`define VRF_RATE_IO_2305 5'h17
`define VRF_RATE_IO_2385 5'h18
// Channel-aware field layout
`define VRF_CA_SIG_W     5
`define VRF_CA_OFS_W     2
`define VRF_CA_TYPE_W    3
// Timestamp: 16 kHz clock, 20 ms block
`define VRF_TS_RATE_HZ   16000
`define VRF_BLOCK_MS     20
`define VRF_TS_STEP      32'h00000140
`define VRF_TS_RESET     32'h00000000
`define VRF_MR_W         3
`define VRF_MR_NONE      3'h7
`endif

//--- hdl/vrf_framer.v
// Compact voice payload framer: size classifier, RTP fields, channel-aware parse
`timescale 1ns/10ps
`include "vrf_consts.vh"
module vrf_framer (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // Transmit side: frame from the encoder
  input wire i_tx_frame_valid,
  input wire i_tx_speech,
  input wire i_tx_talkspurt_start,
  input wire i_tx_first_block,
  input wire i_hdr_full_only,
  input wire i_tx_want_hdr_full,
  // Transmit side: RTP fields to the packetiser
  output reg o_tx_marker,
  output reg [31:0] o_tx_timestamp,
  output reg o_tx_hdr_full,
  output reg o_tx_fields_valid,
  // Receive side: payload size and leading/trailing bits from the stream
  input wire i_rx_valid,
  input wire [11:0] i_rx_size_bits,
  input wire [7:0] i_rx_first_byte,
  input wire [7:0] i_rx_last_byte,
  // Receive side: classification for the decoder
  output reg o_rx_valid,
  output reg o_rx_invalid,
  output reg [4:0] o_rate_code,
  output reg o_rx_interop,
  output reg o_rx_to_decoder,
  output reg [2:0] o_mode_request,
  // Receive side: channel-aware fields
  output reg o_ca_frame,
  output reg [1:0] o_audio_band_code,
  output reg [1:0] o_coder_kind,
  output reg o_partial_redundancy_flag,
  output reg [3:0] o_partial_offset,
  output reg [2:0] o_partial_type,
  output reg o_lp_core,
  output reg o_time_band_extension,
  output reg o_gap_filling
);

  // Partial frame type codes in listed order
  localparam [2:0] PARTIAL_NONE = 3'h0;
  localparam [2:0] PARTIAL_TRANSFORM_FREQ = 3'h1;
  localparam [2:0] PARTIAL_TRANSFORM_TIME_A = 3'h2;
  localparam [2:0] PARTIAL_TRANSFORM_TIME_B = 3'h3;
  localparam [2:0] PARTIAL_ALL_PRED = 3'h4;
  localparam [2:0] PARTIAL_NO_PRED = 3'h5;
  localparam [2:0] PARTIAL_GENERIC_PRED = 3'h6;
  localparam [2:0] PARTIAL_NOISE_EXCITED = 3'h7;

  // Map a payload size to a rate code; one size gives one rate, except the shared 56-bit size, split by the leading bit
  function [4:0] size_to_rate;
    input [11:0] sz;
    input msb;
    begin
      case (sz)
        `VRF_SZ_SID: size_to_rate = `VRF_RATE_P_SID;
        `VRF_SZ_SHARED: size_to_rate = msb ? `VRF_RATE_IO_SID : `VRF_RATE_P_2800;
        `VRF_SZ_P_0720: size_to_rate = `VRF_RATE_P_0720;
        `VRF_SZ_P_0800: size_to_rate = `VRF_RATE_P_0800;
        `VRF_SZ_P_0960: size_to_rate = `VRF_RATE_P_0960;
        `VRF_SZ_P_1320: size_to_rate = `VRF_RATE_P_1320;
        `VRF_SZ_P_1640: size_to_rate = `VRF_RATE_P_1640;
        `VRF_SZ_P_2440: size_to_rate = `VRF_RATE_P_2440;
        `VRF_SZ_P_3200: size_to_rate = `VRF_RATE_P_3200;
        `VRF_SZ_P_4800: size_to_rate = `VRF_RATE_P_4800;
        `VRF_SZ_P_6400: size_to_rate = `VRF_RATE_P_6400;
        `VRF_SZ_P_9600: size_to_rate = `VRF_RATE_P_9600;
        `VRF_SZ_P_12800: size_to_rate = `VRF_RATE_P_12800;
        `VRF_SZ_IO_0660: size_to_rate = `VRF_RATE_IO_0660;
        `VRF_SZ_IO_0885: size_to_rate = `VRF_RATE_IO_0885;
        `VRF_SZ_IO_1265: size_to_rate = `VRF_RATE_IO_1265;
        `VRF_SZ_IO_1425: size_to_rate = `VRF_RATE_IO_1425;
        `VRF_SZ_IO_1585: size_to_rate = `VRF_RATE_IO_1585;
        `VRF_SZ_IO_1825: size_to_rate = `VRF_RATE_IO_1825;
        `VRF_SZ_IO_1985: size_to_rate = `VRF_RATE_IO_1985;
        `VRF_SZ_IO_2305: size_to_rate = `VRF_RATE_IO_2305;
        `VRF_SZ_IO_2385: size_to_rate = `VRF_RATE_IO_2385;
        default: size_to_rate = `VRF_RATE_INVALID;
      endcase
    end
  endfunction

  // Decode the two-bit redundant-copy offset field
  function [3:0] offset_decode;
    input [1:0] code;
    begin
      case (code)
        2'h0: offset_decode = 4'h2;
        2'h1: offset_decode = 4'h3;
        2'h2: offset_decode = 4'h5;
        default: offset_decode = 4'h7;
      endcase
    end
  endfunction

  // Transform-type partial copies versus LP-type partial copies
  function partial_is_transform;
    input [2:0] t;
    begin
      partial_is_transform = (t == PARTIAL_TRANSFORM_FREQ) ||
                             (t == PARTIAL_TRANSFORM_TIME_A) ||
                             (t == PARTIAL_TRANSFORM_TIME_B);
    end
  endfunction

  wire [4:0] rate_now;
  wire is_interop;
  wire is_ca;
  wire [4:0] ca_sig;
  wire [1:0] ca_ofs;
  wire [2:0] ca_type;

  // Classify from size alone; the first byte only splits the shared size
  assign rate_now = size_to_rate(i_rx_size_bits, i_rx_first_byte[7]);
  assign is_interop = rate_now[4] && (rate_now != `VRF_RATE_INVALID);
  // Channel-aware fields: bits leave MSB first, so the head sits in the top bits
  assign ca_sig = i_rx_first_byte[7:3];
  assign ca_ofs = i_rx_last_byte[4:3];
  assign ca_type = i_rx_last_byte[2:0];
  assign is_ca = (rate_now == `VRF_RATE_P_1320);

  // Receive classification, registered one cycle after the size strobe
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_valid <= 1'b0;
      o_rx_invalid <= 1'b0;
      o_rate_code <= `VRF_RATE_INVALID;
      o_rx_interop <= 1'b0;
      o_rx_to_decoder <= 1'b0;
      o_mode_request <= `VRF_MR_NONE;
    end else begin
      o_rx_valid <= i_rx_valid;
      o_rx_invalid <= i_rx_valid && (rate_now == `VRF_RATE_INVALID);
      o_rx_to_decoder <= i_rx_valid && (rate_now != `VRF_RATE_INVALID);
      if (i_rx_valid) begin
        o_rate_code <= rate_now;
        o_rx_interop <= is_interop;
        // Interoperable payloads open with the request; primary ones carry none
        o_mode_request <= is_interop ? i_rx_first_byte[7:5] : `VRF_MR_NONE;
      end
    end
  end

  // Channel-aware parse; only meaningful when the size says 13.2 kbps
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ca_frame <= 1'b0;
      o_audio_band_code <= 2'h0;
      o_coder_kind <= 2'h0;
      o_partial_redundancy_flag <= 1'b0;
      o_partial_offset <= 4'h0;
      o_partial_type <= PARTIAL_NONE;
      o_lp_core <= 1'b0;
      o_time_band_extension <= 1'b0;
      o_gap_filling <= 1'b0;
    end else if (i_rx_valid) begin
      o_ca_frame <= is_ca && ca_sig[0];
      o_audio_band_code <= ca_sig[4:3];
      o_coder_kind <= ca_sig[2:1];
      o_partial_redundancy_flag <= is_ca && ca_sig[0];
      if (is_ca && ca_sig[0]) begin
        o_partial_offset <= offset_decode(ca_ofs);
        o_partial_type <= ca_type;
        // Core choice follows the partial kind; LP pairs with band extension
        o_lp_core <= !partial_is_transform(ca_type) && (ca_type != PARTIAL_NONE);
        o_time_band_extension <= !partial_is_transform(ca_type);
        o_gap_filling <= partial_is_transform(ca_type);
      end else begin
        // Flag clear or size not 13.2: tail bits are speech, not redundancy
        o_partial_offset <= 4'h0;
        o_partial_type <= PARTIAL_NONE;
        o_lp_core <= 1'b0;
        o_time_band_extension <= 1'b0;
        o_gap_filling <= 1'b0;
      end
    end
  end

  // Transmit RTP fields: timestamp steps per block, marker on talkspurt start
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tx_timestamp <= `VRF_TS_RESET;
      o_tx_marker <= 1'b0;
      o_tx_hdr_full <= 1'b0;
      o_tx_fields_valid <= 1'b0;
    end else begin
      o_tx_fields_valid <= i_tx_frame_valid;
      if (i_tx_frame_valid) begin
        // Every block advances time, speech or not, so silence keeps the clock
        o_tx_timestamp <= o_tx_timestamp + `VRF_TS_STEP;
        o_tx_marker <= i_tx_first_block && i_tx_speech && i_tx_talkspurt_start;
        o_tx_hdr_full <= i_hdr_full_only || i_tx_want_hdr_full;
      end
    end
  end

  // Payload bit placement is done by the packetiser; sizes above cover padding

endmodule // vrf_framer

//--- verif/vrf_framer_chk.sv
// Checker for the compact voice payload framer ports
`timescale 1ns/10ps
module vrf_framer_chk (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // Watched inputs
  input wire i_tx_frame_valid,
  input wire i_tx_speech,
  input wire i_tx_talkspurt_start,
  input wire i_tx_first_block,
  input wire i_hdr_full_only,
  input wire i_tx_want_hdr_full,
  input wire i_rx_valid,
  input wire [11:0] i_rx_size_bits,
  input wire [7:0] i_rx_first_byte,
  input wire [7:0] i_rx_last_byte,
  // Watched outputs
  input wire o_tx_marker,
  input wire [31:0] o_tx_timestamp,
  input wire o_tx_hdr_full,
  input wire o_tx_fields_valid,
  input wire o_rx_valid,
  input wire o_rx_invalid,
  input wire [4:0] o_rate_code,
  input wire o_rx_to_decoder,
  input wire [2:0] o_partial_type
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Answers come exactly one cycle after a taken request, and rx answers never unasked
  a_rx_answer: assert property (i_rx_valid |=> o_rx_valid) else $error("rx answer missing");
  a_rx_quiet: assert property (!i_rx_valid |=> !o_rx_valid) else $error("rx answer unasked");
  a_tx_answer: assert property (i_tx_frame_valid |=> o_tx_fields_valid)
    else $error("tx answer missing");
  a_ts_step: assert property (o_tx_fields_valid |-> o_tx_timestamp == $past(o_tx_timestamp) + 32'h140) else $error("timestamp step wrong");
  a_marker_rule: assert property (i_tx_frame_valid |=> o_tx_marker == $past(i_tx_speech && i_tx_first_block && i_tx_talkspurt_start)) else $error("marker wrong");
  a_format_pick: assert property (i_tx_frame_valid |=> o_tx_hdr_full == $past(i_hdr_full_only || i_tx_want_hdr_full)) else $error("format wrong");
  a_invalid_block: assert property (o_rx_invalid |-> o_rx_valid && !o_rx_to_decoder && o_rate_code == 5'h1F) else $error("invalid passed");
  a_shared_split: assert property (i_rx_valid && i_rx_size_bits == 12'h038 |=> o_rate_code == ($past(i_rx_first_byte[7]) ? 5'h02 : 5'h01)) else $error("56 split wrong");
  a_ca_type: assert property (i_rx_valid && i_rx_size_bits == 12'h108 && i_rx_first_byte[3] |=> o_partial_type == $past(i_rx_last_byte[2:0])) else $error("type wrong");
endmodule // vrf_framer_chk
bind vrf_framer vrf_framer_chk u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_tx_frame_valid(i_tx_frame_valid), .i_tx_speech(i_tx_speech),
  .i_tx_talkspurt_start(i_tx_talkspurt_start), .i_tx_first_block(i_tx_first_block),
  .i_hdr_full_only(i_hdr_full_only), .i_tx_want_hdr_full(i_tx_want_hdr_full),
  .i_rx_valid(i_rx_valid), .i_rx_size_bits(i_rx_size_bits), .i_rx_first_byte(i_rx_first_byte),
  .i_rx_last_byte(i_rx_last_byte), .o_tx_marker(o_tx_marker), .o_tx_timestamp(o_tx_timestamp),
  .o_tx_hdr_full(o_tx_hdr_full), .o_tx_fields_valid(o_tx_fields_valid), .o_rx_valid(o_rx_valid),
  .o_rx_invalid(o_rx_invalid), .o_rate_code(o_rate_code), .o_rx_to_decoder(o_rx_to_decoder),
  .o_partial_type(o_partial_type));

//--- verif/vrf_stream_src.sv
// Packet stream model presenting payload descriptors to the framer
`timescale 1ns/10ps
module vrf_stream_src (
  // Clock and bench request
  input wire i_sys_clk,
  input wire i_go,
  input wire [27:0] i_desc,
  // Descriptor lines toward the framer
  output logic o_valid,
  output logic [27:0] o_desc
);
  logic go;
  initial {o_valid, o_desc} = 29'h0;
  // Sample at the edge, drive just after; idle lines invert so nothing stale looks valid
  always @(posedge i_sys_clk) begin
    go = i_go;
    #1;
    o_valid = go;
    o_desc = go ? i_desc : ~o_desc;
  end
endmodule // vrf_stream_src

//--- verif/vrf_framer_bench.sv
// Self-checking bench for the compact voice payload framer
`timescale 1ns/10ps
module vrf_framer_bench;
  logic i_sys_clk = 0, i_rst_n = 0, go = 0, txv = 0, sp = 0, ts = 0, fb = 0, ho = 0, wh = 0;
  logic [27:0] desc = 0, rdesc;
  logic rv, mk, hf, fv, ov, inv, io, dec, ca, pf, lp, time_band_extension, gf;
  logic [31:0] tst;
  logic [4:0] rc;
  logic [3:0] ofs;
  logic [2:0] mr, pt;
  logic [1:0] bw, ck;
  int n_fail = 0, tests_run = 0, cyc = 0, nfr = 0;
  int sz_tab [22] = '{48, 56, 136, 144, 160, 184, 192, 256, 264, 288, 320, 328, 368, 400, 464,
    480, 488, 640, 960, 1280, 1920, 2560};
  always #4 i_sys_clk = ~i_sys_clk;
  vrf_stream_src u_src (.i_sys_clk(i_sys_clk), .i_go(go), .i_desc(desc), .o_valid(rv),
    .o_desc(rdesc));
  vrf_framer u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_tx_frame_valid(txv),
    .i_tx_speech(sp), .i_tx_talkspurt_start(ts), .i_tx_first_block(fb), .i_hdr_full_only(ho),
    .i_tx_want_hdr_full(wh), .o_tx_marker(mk), .o_tx_timestamp(tst), .o_tx_hdr_full(hf),
    .o_tx_fields_valid(fv), .i_rx_valid(rv), .i_rx_size_bits(rdesc[27:16]),
    .i_rx_first_byte(rdesc[15:8]), .i_rx_last_byte(rdesc[7:0]), .o_rx_valid(ov),
    .o_rx_invalid(inv), .o_rate_code(rc), .o_rx_interop(io), .o_rx_to_decoder(dec),
    .o_mode_request(mr), .o_ca_frame(ca), .o_audio_band_code(bw), .o_coder_kind(ck),
    .o_partial_redundancy_flag(pf), .o_partial_offset(ofs), .o_partial_type(pt),
    .o_lp_core(lp), .o_time_band_extension(time_band_extension), .o_gap_filling(gf));
  // Expected rate code from size alone, with the 56-bit split on the leading bit
  function automatic logic [4:0] rate_of(input logic [11:0] s, input logic msb);
    case (s)
      48: return 5'h00;     56: return msb ? 5'h02 : 5'h01;
      144: return 5'h03;    160: return 5'h04;  192: return 5'h05;  264: return 5'h06;
      328: return 5'h07;    488: return 5'h08;  640: return 5'h09;  960: return 5'h0A;
      1280: return 5'h0B;   1920: return 5'h0C; 2560: return 5'h0D; 136: return 5'h10;
      184: return 5'h11;    256: return 5'h12;  288: return 5'h13;  320: return 5'h14;
      368: return 5'h15;    400: return 5'h16;  464: return 5'h17;  480: return 5'h18;
      default: return 5'h1F;
    endcase
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One descriptor through the stream model, judged the cycle after the framer takes it
  task automatic rx(input logic [11:0] s, input logic [7:0] f, input logic [7:0] l);
    logic [4:0] r;
    logic x;
    r = rate_of(s, f[7]);
    x = r[4] && r != 5'h1F;
    @(posedge i_sys_clk) #1 {go, desc} = {1'b1, s, f, l};
    @(posedge i_sys_clk) #1 go = 0;
    @(posedge i_sys_clk) #1;
    chk({ov, rc, inv, dec}, {1'b1, r, r == 5'h1F, r != 5'h1F});
    chk({io, mr}, {x, x ? f[7:5] : 3'h7});
    if (s == 264 && f[3]) begin
      chk({ca, pf, bw, ck}, {2'b11, f[7:4]});
      chk(ofs, l[4:3] == 0 ? 2 : l[4:3] == 1 ? 3 : l[4:3] == 2 ? 5 : 7);
      chk(pt, l[2:0]);
      if (l[2:0] != 0) chk(gf, l[2:0] < 4);
      chk({lp, time_band_extension}, {l[2:0] > 3, l[2:0] == 0 || l[2:0] > 3});
    end else if (s == 264) begin
      chk({ca, pf}, 2'b00);
      chk({ofs, pt}, 7'h00);
    end
  endtask
  // Timeout guard sized well above the expected run length
  always @(posedge i_sys_clk) if (++cyc > 20000) begin
    n_fail++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h6779));
    repeat (6) @(posedge i_sys_clk);
    #1 i_rst_n = 1;
    chk({rc, mr, tst}, {5'h1F, 3'h7, 32'h0});
    foreach (sz_tab[i]) rx(sz_tab[i], $urandom, $urandom);
    rx(56, 8'h7F, 8'h00);
    rx(56, 8'h80, 8'hFF);
    for (int i = 0; i < 40; i++) begin
      rx(264, $urandom | (i[0] << 3), i);
      rx($urandom, $urandom, $urandom);
    end
    // Encoder frames with random qualifiers; valid drops so each pass is one frame
    for (int i = 0; i < 60; i++) begin
      @(posedge i_sys_clk) #1 {txv, sp, ts, fb, ho, wh} = {1'b1, 5'($urandom)};
      @(posedge i_sys_clk) #1 txv = 0;
      nfr++;
      chk({fv, mk, hf}, {1'b1, sp & ts & fb, ho | wh});
      chk(tst, nfr * 320);
    end
    txv = 0;
    stop_test();
  end
endmodule // vrf_framer_bench
